//--- verilog/mac_pkg.sv
`default_nettype none
package mac_pkg;

	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;

	// Byte addresses of the unit's registers.
	localparam logic [ADDR_W-1:0] OFS_COMMAND = 12'hFA4;
	localparam logic [ADDR_W-1:0] OFS_STATUS  = 12'hFA5;
	localparam logic [ADDR_W-1:0] OFS_MPL_LO  = 12'hFA6;
	localparam logic [ADDR_W-1:0] OFS_MPL_HI  = 12'hFA7;
	localparam logic [ADDR_W-1:0] OFS_MPC_LO  = 12'hFA8;
	localparam logic [ADDR_W-1:0] OFS_MPC_HI  = 12'hFA9;
	localparam logic [ADDR_W-1:0] OFS_RES_B0  = 12'hFAA;
	localparam logic [ADDR_W-1:0] OFS_RES_B3  = 12'hFAD;

	// Command register fields.
	localparam int CMD_CLEAR_BIT  = 7;
	localparam int CMD_MODE_LSB   = 1;
	localparam int CMD_ENABLE_BIT = 0;
	localparam logic [7:0] CMD_ONES_MASK = 8'h70;
	localparam logic [7:0] CMD_RESET     = 8'h70;

	// Status register fields.
	localparam int STS_CARRY_BIT = 4;
	localparam int STS_ZERO_BIT  = 3;
	localparam int STS_SIGN_BIT  = 2;
	localparam int STS_OVFN_BIT  = 1;
	localparam int STS_BUSY_BIT  = 0;
	localparam logic [7:0] STS_ONES_MASK = 8'hE0;
	localparam logic [7:0] STS_RESET     = 8'hE0;

	localparam logic [15:0] OPERAND_RESET = 16'h0000;
	localparam logic [31:0] WORD_RESET    = 32'h0000_0000;
	localparam logic [7:0]  UNMAPPED_READ = 8'h00;

	// Clock cycles the busy flag stays set for one calculation.
	localparam int BUSY_FLAG_CYCLES = 4;

	// Arithmetic mode codes; bit 1 selects signed, bit 0 selects accumulate.
	localparam logic [2:0] MODE_UMUL  = 3'h0;
	localparam logic [2:0] MODE_UMAC  = 3'h1;
	localparam logic [2:0] MODE_SMUL  = 3'h2;
	localparam logic [2:0] MODE_SMAC  = 3'h3;
	localparam int MODE_RSVD_BIT   = 2;
	localparam int MODE_SIGNED_BIT = 1;
	localparam int MODE_ACCUM_BIT  = 0;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_BUSY_FLAG = 2'b10
	} mac_state_e;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} mac_bus_s;

endpackage
`default_nettype wire

//--- verilog/mac_unit.sv
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Enable bit written 1 turns the unit on, written 0 turns it off.
// - Mode field: 000 umul, 001 umac, 010 smul, 011 smac; 1xx reserved.
// - Clear bit resets result, addend and status; operands and command kept.
// - Clear bit drops back to 0 by itself one cycle after being set.
// - Clear bit cannot be set while a calculation is busy.
// - Writing the mode field leaves status, operands, result and addend alone.
// - Command bits 6..4 and status bits 7..5 always read 1.
// - Carry flag shows carry out of the 32-bit accumulate sum.
// - Zero flag is set at the end of a calculation whose 32-bit result is zero.
// - Sign flag is set at the end of a signed calculation whose result is negative.
// - Overflow flag is active low: in accumulate modes 0 means overflow occurred.
// - Busy flag is 1 while a calculation is in progress.
// - Result flags change only at the end of a calculation or on clear and initialisation, not on reads.
// - Addend writes leave zero and sign flags unchanged.
// - Plain multiply modes give overflow and carry flags of 0.
// - Multiplicand low byte then high byte starts a calculation.
// - A lone high multiplicand byte is dropped; a lone low byte is kept.
// - Signed modes use bit 15 of operands and bit 31 of the result as signs.
// - Addend writes also overwrite the shared result byte.
// - Outside the normal run modes every unit register is initialised.
// - Accumulate modes add the addend to the product into the result.
// - Disabling initialises data registers; other command bits are kept.
// - Operand and addend writes are taken only while the unit is enabled.
module mac_unit
	import mac_pkg::*;
#(
	parameter int BUSY_FLAG_LEN = BUSY_FLAG_CYCLES
) (
	input  wire logic              ref_clk,     // System clock.
	input  wire logic              reset,       // Synchronous reset, active high.
	input  wire logic              clk_en,      // Freezes all state while low.
	input  wire logic              normal_mode, // High in either normal run mode.
	input  wire mac_bus_s          bus,         // Register access request.
	output logic      [DATA_W-1:0] rd_data_r    // Read data, cycle after strobe.
);

	localparam logic [7:0] BUSY_FLAG_LAST = 8'(BUSY_FLAG_LEN - 1);

	mac_state_e  state_r;
	logic [7:0]  count_r;
	logic        enable_r;
	logic [2:0]  mode_r;
	logic        clear_r;
	logic        carry_r;
	logic        zero_r;
	logic        sign_r;
	logic        ovf_n_r;
	logic [15:0] mplier_r;
	logic [15:0] mcand_r;
	logic        lo_armed_r;
	logic [15:0] op_a_r;
	logic [15:0] op_b_r;
	logic [2:0]  op_mode_r;
	logic [31:0] result_r;
	logic [31:0] addend_r;

	logic        busy;
	logic        wr_cmd;
	logic        clear_go;
	logic        data_init;
	logic        oper_init;
	logic        start;
	logic        done;
	logic        wr_data_ok;
	logic [1:0]  byte_sel;
	logic        in_shared;
	logic signed [16:0] a_ext;
	logic signed [16:0] b_ext;
	logic signed [33:0] prod_full;
	logic [31:0] prod;
	logic [32:0] sum;
	logic [31:0] busy_flag_res;
	logic        busy_flag_carry;
	logic        busy_flag_ovf;
	logic [7:0]  cmd_view;
	logic [7:0]  sts_view;
	logic [7:0]  rd_mux;

	// Busy flag follows the state machine.
	// busy while calculating
	assign busy = (state_r == ST_BUSY_FLAG);

	assign wr_cmd = bus.wr && (bus.addr == OFS_COMMAND);
	assign clear_go = wr_cmd && bus.wdata[CMD_CLEAR_BIT] && !busy;
	assign oper_init = !normal_mode || !enable_r;
	assign data_init = oper_init || clear_go;
	assign wr_data_ok = bus.wr && enable_r && normal_mode;
	assign start = wr_data_ok && (bus.addr == OFS_MPC_HI) && lo_armed_r && !busy;
	assign done = busy && (count_r == BUSY_FLAG_LAST);

	assign in_shared = (bus.addr >= OFS_RES_B0) && (bus.addr <= OFS_RES_B3);
	assign byte_sel  = 2'(bus.addr - OFS_RES_B0);

	// Arithmetic on the operands latched when the calculation started.
	always_comb begin
		a_ext = {op_mode_r[MODE_SIGNED_BIT] & op_a_r[15], op_a_r};
		b_ext = {op_mode_r[MODE_SIGNED_BIT] & op_b_r[15], op_b_r};
		prod_full = a_ext * b_ext;
		prod = prod_full[31:0];
		sum = {1'b0, prod} + {1'b0, addend_r};
		if (op_mode_r[MODE_ACCUM_BIT]) begin
			busy_flag_res = sum[31:0];
			busy_flag_carry = sum[32];
			if (op_mode_r[MODE_SIGNED_BIT]) begin
				busy_flag_ovf = (prod[31] == addend_r[31]) && (sum[31] != prod[31]);
			end else begin
				busy_flag_ovf = sum[32];
			end
		end else begin
			busy_flag_res = prod;
			busy_flag_carry = 1'b0;
			busy_flag_ovf = 1'b0;
		end
	end

	// Calculation sequencer.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_r <= ST_IDLE;
			count_r <= 8'h00;
		end else if (clk_en) begin
			if (oper_init) begin
				state_r <= ST_IDLE;
				count_r <= 8'h00;
			end else begin
				case (state_r)
					ST_IDLE: begin
						count_r <= 8'h00;
						if (start) begin
							state_r <= ST_BUSY_FLAG;
						end
					end
					ST_BUSY_FLAG: begin
						count_r <= count_r + 8'h01;
						if (done) begin
							state_r <= ST_IDLE;
						end
					end
					default: begin
						state_r <= ST_IDLE;
						count_r <= 8'h00;
					end
				endcase
			end
		end
	end

	// Command register.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			enable_r <= CMD_RESET[CMD_ENABLE_BIT];
			mode_r   <= CMD_RESET[CMD_MODE_LSB +: 3];
			clear_r  <= CMD_RESET[CMD_CLEAR_BIT];
		end else if (clk_en) begin
			if (!normal_mode) begin
				enable_r <= CMD_RESET[CMD_ENABLE_BIT];
				mode_r   <= CMD_RESET[CMD_MODE_LSB +: 3];
				clear_r  <= CMD_RESET[CMD_CLEAR_BIT];
			end else begin
				clear_r <= clear_go;
				if (wr_cmd) begin
					enable_r <= bus.wdata[CMD_ENABLE_BIT];
					mode_r <= bus.wdata[CMD_MODE_LSB +: 3];
				end
			end
		end
	end

	// Result flags.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			carry_r <= STS_RESET[STS_CARRY_BIT];
			zero_r  <= STS_RESET[STS_ZERO_BIT];
			sign_r  <= STS_RESET[STS_SIGN_BIT];
			ovf_n_r <= STS_RESET[STS_OVFN_BIT];
		end else if (clk_en) begin
			if (data_init) begin
				carry_r <= STS_RESET[STS_CARRY_BIT];
				zero_r  <= STS_RESET[STS_ZERO_BIT];
				sign_r  <= STS_RESET[STS_SIGN_BIT];
				ovf_n_r <= STS_RESET[STS_OVFN_BIT];
			end else if (done) begin
				carry_r <= busy_flag_carry;
				zero_r <= (busy_flag_res == WORD_RESET);
				sign_r <= op_mode_r[MODE_SIGNED_BIT] & busy_flag_res[31];
				ovf_n_r <= op_mode_r[MODE_ACCUM_BIT] & ~busy_flag_ovf;
			end
		end
	end

	// Multiplier register, byte writable.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			mplier_r <= OPERAND_RESET;
		end else if (clk_en) begin
			if (oper_init) begin
				mplier_r <= OPERAND_RESET;
			end else if (wr_data_ok && bus.addr == OFS_MPL_LO) begin
				mplier_r[7:0] <= bus.wdata;
			end else if (wr_data_ok && bus.addr == OFS_MPL_HI) begin
				mplier_r[15:8] <= bus.wdata;
			end
		end
	end

	// Multiplicand register; the high byte lands only after a low byte.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			mcand_r    <= OPERAND_RESET;
			lo_armed_r <= 1'b0;
		end else if (clk_en) begin
			if (oper_init) begin
				mcand_r    <= OPERAND_RESET;
				lo_armed_r <= 1'b0;
			end else if (wr_data_ok && bus.addr == OFS_MPC_LO) begin
				mcand_r[7:0] <= bus.wdata;
				lo_armed_r   <= 1'b1;
			end else if (wr_data_ok && bus.addr == OFS_MPC_HI) begin
				if (lo_armed_r) begin
					mcand_r[15:8] <= bus.wdata;
				end
				lo_armed_r <= 1'b0;
			end
		end
	end

	// Operands captured at start so later operand writes cannot disturb the run.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			op_a_r    <= OPERAND_RESET;
			op_b_r    <= OPERAND_RESET;
			op_mode_r <= MODE_UMUL;
		end else if (clk_en) begin
			if (start) begin
				op_a_r    <= mplier_r;
				op_b_r    <= {bus.wdata, mcand_r[7:0]};
				op_mode_r <= mode_r;
			end
		end
	end

	// Result and addend share addresses.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			result_r <= WORD_RESET;
			addend_r <= WORD_RESET;
		end else if (clk_en) begin
			if (data_init) begin
				result_r <= WORD_RESET;
				addend_r <= WORD_RESET;
			end else if (done) begin
				result_r <= busy_flag_res;
			end else if (wr_data_ok && in_shared) begin
				addend_r[byte_sel*8 +: 8] <= bus.wdata;
				result_r[byte_sel*8 +: 8] <= bus.wdata;
			end
		end
	end

	// Read views with fixed-one bits.
	always_comb begin
		cmd_view = CMD_ONES_MASK;
		cmd_view[CMD_CLEAR_BIT] = clear_r;
		cmd_view[CMD_MODE_LSB +: 3] = mode_r;
		cmd_view[CMD_ENABLE_BIT] = enable_r;
		sts_view = STS_ONES_MASK;
		sts_view[STS_CARRY_BIT] = carry_r;
		sts_view[STS_ZERO_BIT] = zero_r;
		sts_view[STS_SIGN_BIT] = sign_r;
		sts_view[STS_OVFN_BIT] = ovf_n_r;
		sts_view[STS_BUSY_BIT] = busy;
		if (bus.addr == OFS_COMMAND) begin
			rd_mux = cmd_view;
		end else if (bus.addr == OFS_STATUS) begin
			rd_mux = sts_view;
		end else if (bus.addr == OFS_MPL_LO) begin
			rd_mux = mplier_r[7:0];
		end else if (bus.addr == OFS_MPL_HI) begin
			rd_mux = mplier_r[15:8];
		end else if (bus.addr == OFS_MPC_LO) begin
			rd_mux = mcand_r[7:0];
		end else if (bus.addr == OFS_MPC_HI) begin
			rd_mux = mcand_r[15:8];
		end else if (in_shared) begin
			rd_mux = result_r[byte_sel*8 +: 8];
		end else begin
			rd_mux = UNMAPPED_READ;
		end
	end

	// Read data register; reads have no side effects.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rd_data_r <= UNMAPPED_READ;
		end else if (clk_en) begin
			if (bus.rd) begin
				rd_data_r <= rd_mux;
			end else begin
				rd_data_r <= UNMAPPED_READ;
			end
		end
	end

endmodule
`default_nettype wire

//--- testbench/mac_unit_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module mac_unit_asserts
	import mac_pkg::*;
#(
	parameter int BUSY_FLAG_LEN = BUSY_FLAG_CYCLES
) (
	input wire logic              ref_clk,     // Clock.
	input wire logic              reset,       // Reset.
	input wire logic              clk_en,      // Clock enable.
	input wire logic              normal_mode, // Run mode.
	input wire mac_bus_s          bus,         // Request.
	input wire logic [DATA_W-1:0] rd_data_r    // Read data.
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	logic en_r;
	logic lo_r;
	int   cnt_r;
	wire  go = clk_en && normal_mode;
	wire  rd_cmd = go && bus.rd && bus.addr == OFS_COMMAND;
	wire  rd_sts = go && bus.rd && bus.addr == OFS_STATUS;
	wire  wr_cmd = go && bus.wr && bus.addr == OFS_COMMAND;
	wire  wr_lo = go && en_r && bus.wr && bus.addr == OFS_MPC_LO;
	wire  wr_hi = go && en_r && bus.wr && bus.addr == OFS_MPC_HI;
	// Follows the enable, the byte order and the busy count from the bus.
	always_ff @(posedge ref_clk) begin
		if (reset || !normal_mode) begin
			en_r <= 1'b0;
			lo_r <= 1'b0;
			cnt_r <= 0;
		end else if (clk_en) begin
			if (wr_cmd)
				en_r <= bus.wdata[0];
			if (!en_r)
				lo_r <= 1'b0;
			else if (wr_lo)
				lo_r <= 1'b1;
			else if (wr_hi)
				lo_r <= 1'b0;
			if (!en_r)
				cnt_r <= 0;
			else if (wr_hi && lo_r && cnt_r == 0)
				cnt_r <= BUSY_FLAG_LEN;
			else if (cnt_r > 0)
				cnt_r <= cnt_r - 1;
		end
	end
	sequence s_cmd_wr_rd;
		wr_cmd ##1 go && !bus.wr && !bus.rd ##1 rd_cmd;
	endsequence
	property p_cmd_ones;
		rd_cmd |=> rd_data_r[6:4] == 3'h7;
	endproperty
	a_cmd_ones: assert property (p_cmd_ones) else $error("command ones");
	property p_sts_ones;
		rd_sts |=> rd_data_r[7:5] == 3'h7;
	endproperty
	a_sts_ones: assert property (p_sts_ones) else $error("status ones");
	property p_en_rb;
		s_cmd_wr_rd |=> rd_data_r[0] == $past(bus.wdata[0], 3);
	endproperty
	a_en_rb: assert property (p_en_rb) else $error("enable bit");
	property p_mode_rb;
		s_cmd_wr_rd |=> rd_data_r[3:1] == $past(bus.wdata[3:1], 3);
	endproperty
	a_mode_rb: assert property (p_mode_rb) else $error("mode field");
	property p_clr_drop;
		s_cmd_wr_rd |=> !rd_data_r[7];
	endproperty
	a_clr_drop: assert property (p_clr_drop) else $error("clear bit stuck");
	property p_busy_on;
		rd_sts && cnt_r != 0 |=> rd_data_r[0];
	endproperty
	a_busy_on: assert property (p_busy_on) else $error("busy missing");
	property p_busy_off;
		rd_sts && cnt_r == 0 |=> !rd_data_r[0];
	endproperty
	a_busy_off: assert property (p_busy_off) else $error("busy too long");
	property p_init;
		clk_en && !normal_mode ##1 go && !bus.wr ##1 rd_cmd |=> rd_data_r == CMD_RESET;
	endproperty
	a_init: assert property (p_init) else $error("command not initialised");
	property p_unmapped;
		go && bus.rd && bus.addr > OFS_RES_B3 |=> rd_data_r == UNMAPPED_READ;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read");
	c_busy: cover property (rd_sts && cnt_r != 0);
	c_clear: cover property (wr_cmd && bus.wdata[7]);
	c_init: cover property (clk_en && !normal_mode);
endmodule
`default_nettype wire

//--- testbench/mac_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
module mac_cpu_model
	import mac_pkg::*;
(
	input  wire logic              ref_clk,   // Clock.
	input  wire logic [DATA_W-1:0] rd_data_r, // Read data.
	output var  mac_bus_s          bus        // Request.
);
	initial
		bus = '0;
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge ref_clk);
		bus <= '0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge ref_clk);
		bus <= '0;
		@(negedge ref_clk);
		d = rd_data_r;
	endtask
	task automatic busy_flag(input logic [15:0] a, input logic [15:0] b);
		wr(OFS_MPL_LO, a[7:0]);
		wr(OFS_MPL_HI, a[15:8]);
		wr(OFS_MPC_LO, b[7:0]);
		wr(OFS_MPC_HI, b[15:8]);
	endtask
	task automatic idle(output logic ok);
		logic [7:0] s;
		ok = 1'b0;
		for (int i = 0; i < 20 && !ok; i++) begin
			rd(OFS_STATUS, s);
			ok = (s[0] === 1'b0);
		end
	endtask
	task automatic addend(input logic [31:0] v);
		for (int i = 0; i < 4; i++)
			wr(OFS_RES_B0 + 12'(i), v[8*i+:8]);
	endtask
	task automatic res(output logic [31:0] r);
		logic [7:0] b;
		for (int i = 0; i < 4; i++) begin
			rd(OFS_RES_B0 + 12'(i), b);
			r[8*i+:8] = b;
		end
	endtask
endmodule
`default_nettype wire

//--- testbench/test_mac_unit.sv
`timescale 1ns/10ps
`default_nettype none
module test_mac_unit
	import mac_pkg::*;
;
	typedef struct packed {
		logic [2:0]  m;
		logic [15:0] a;
		logic [15:0] b;
		logic [31:0] c;
		logic [31:0] r;
		logic [7:0]  s;
	} mac_row_s;
	logic        ref_clk = 1'b0;
	logic        reset = 1'b1;
	logic        clk_en = 1'b1;
	logic        normal_mode = 1'b1;
	mac_bus_s    bus;
	logic [7:0]  rd_data_r;
	logic [31:0] r;
	logic [7:0]  d;
	int          mismatches = 0;
	int          checks = 0;
	mac_row_s    rows [8] = '{
		'{3'h0, 16'h1234, 16'h0010, 32'h0, 32'h00012340, 8'hE0},
		'{3'h0, 16'h0000, 16'hABCD, 32'h0, 32'h0, 8'hE8},
		'{3'h1, 16'hFFFF, 16'hFFFF, 32'h0001FFFF, 32'h0, 8'hF8},
		'{3'h1, 16'h0002, 16'h0003, 32'h10, 32'h16, 8'hE2},
		'{3'h2, 16'hFFFF, 16'h0002, 32'h0, 32'hFFFFFFFE, 8'hE4},
		'{3'h3, 16'h8000, 16'h8000, 32'h40000000, 32'h80000000, 8'hE4},
		'{3'h4, 16'h0003, 16'h0005, 32'h0, 32'hF, 8'hE0},
		'{3'h3, 16'hFFFF, 16'h0003, 32'h5, 32'h2, 8'hF2}
	};
	always #50 ref_clk = ~ref_clk;
	mac_unit dut_u (
		.ref_clk(ref_clk),
		.reset(reset),
		.clk_en(clk_en),
		.normal_mode(normal_mode),
		.bus(bus),
		.rd_data_r(rd_data_r)
	);
	mac_cpu_model cpu_u (
		.ref_clk(ref_clk),
		.rd_data_r(rd_data_r),
		.bus(bus)
	);
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic wait_idle();
		logic ok;
		cpu_u.idle(ok);
		if (!ok) begin
			mismatches++;
			end_of_test();
		end
	endtask
	task automatic rst_chk();
		@(posedge ref_clk);
		reset <= 1'b1;
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
		for (int i = 0; i < 13; i++) begin
			cpu_u.rd(OFS_COMMAND + 12'(i), d);
			chk("reset value", d, i == 0 ? 8'h70 : i == 1 ? 8'hE0 : 8'h00);
		end
	endtask
	initial begin
		rst_chk();
		foreach (rows[i]) begin
			cpu_u.wr(OFS_COMMAND, {4'h0, rows[i].m, 1'b1});
			cpu_u.addend(rows[i].c);
			cpu_u.busy_flag(rows[i].a, rows[i].b);
			wait_idle();
			cpu_u.res(r);
			chk("result", r, rows[i].r);
			cpu_u.rd(OFS_STATUS, d);
			chk("status", d, rows[i].s);
		end
		cpu_u.rd(OFS_STATUS, d);
		chk("status again", d, 8'hF2);
		cpu_u.wr(OFS_RES_B0, 8'h00);
		cpu_u.res(r);
		chk("addend over result", r, 32'h0);
		cpu_u.rd(OFS_STATUS, d);
		chk("flags after addend", d, 8'hF2);
		cpu_u.wr(OFS_COMMAND, 8'h01);
		cpu_u.rd(OFS_STATUS, d);
		chk("flags after mode", d, 8'hF2);
		cpu_u.busy_flag(16'h0002, 16'h0003);
		cpu_u.wr(OFS_COMMAND, 8'h81);
		wait_idle();
		cpu_u.res(r);
		chk("clear while busy", r, 32'h6);
		cpu_u.wr(OFS_COMMAND, 8'h81);
		cpu_u.rd(OFS_COMMAND, d);
		chk("clear bit", d, 8'h71);
		cpu_u.res(r);
		chk("cleared result", r, 32'h0);
		cpu_u.rd(OFS_MPL_LO, d);
		chk("multiplier kept", d, 8'h02);
		cpu_u.wr(OFS_MPC_HI, 8'h55);
		cpu_u.rd(OFS_MPC_HI, d);
		chk("lone high byte", d, 8'h00);
		cpu_u.wr(OFS_MPC_LO, 8'h77);
		cpu_u.rd(OFS_MPC_LO, d);
		chk("lone low byte", d, 8'h77);
		@(posedge ref_clk);
		clk_en <= 1'b0;
		cpu_u.wr(OFS_MPC_LO, 8'h99);
		clk_en <= 1'b1;
		cpu_u.rd(OFS_MPC_LO, d);
		chk("frozen write", d, 8'h77);
		cpu_u.wr(OFS_COMMAND, 8'h06);
		cpu_u.rd(OFS_MPC_LO, d);
		chk("disabled operand", d, 8'h00);
		cpu_u.wr(OFS_MPL_LO, 8'h12);
		cpu_u.rd(OFS_MPL_LO, d);
		chk("disabled write", d, 8'h00);
		@(posedge ref_clk);
		normal_mode <= 1'b0;
		@(posedge ref_clk);
		normal_mode <= 1'b1;
		cpu_u.rd(OFS_COMMAND, d);
		chk("mode exit", d, 8'h70);
		rst_chk();
		end_of_test();
	end
endmodule
bind mac_unit mac_unit_asserts #(.BUSY_FLAG_LEN(BUSY_FLAG_LEN)) chk_u (
	.ref_clk(ref_clk),
	.reset(reset),
	.clk_en(clk_en),
	.normal_mode(normal_mode),
	.bus(bus),
	.rd_data_r(rd_data_r)
);
`default_nettype wire
